// ### port_alt_function_override.sv
/*
 * pin override logic for ports e, f and g: peripherals on one side, pads on the other,
 * port, direction and pin registers behind a classic wishbone slave
 * assumes peripherals run on clk_i; pad inputs are asynchronous; pads resolve oe/pu
 */
// The implementer's own choices: the Wishbone register port and the placing of the registers.
// Function
// - pe5 value follows timer3 compare c when enabled; direction stays software's.
// - pe4 value follows timer3 compare b when enabled; direction stays software's.
// - pe3 value follows timer3 compare a when enabled; pe3 feeds comparator negative.
// - enabled external interrupts force pe7..pe4 input buffers on; pe7 capture, pe6 clock.
// - pe2 sync clock driven out when its output enable is set; direction stays software's when cleared.
// - serial0 receiver forces pe0 to input; received data taken from pin.
// - receiver-forced pe0 pull-up equals port bit and not global pull-up disable.
// - serial0 transmitter forces pe1 output, pull-up off, driving transmit data unless program download is active.
// - pe0 feeds pin change 8; buffer forced on when mask and group enabled.
// - small package program download: pe1 data out, pe0 data in.
// - test port enable forces pf7, pf5, pf4 pull-ups on, even in reset.
// - test port enable takes pf7..pf4 from general io; tdi, tms, tck inputs.
// - tdo on pf6 driven only in instruction or data shift states.
// - test port signals are delivered as two-stage synchronised clk_i levels, taken ahead of the input buffer gate.
// - pf3..pf0 are converter channels with no digital overrides.
// - pe2 feeds comparator positive input, sampled from the pin ahead of the input buffer gate.
// - pg2..pg0 external memory strobes; pg5 timer0 compare b; pg4, pg3 oscillator.
`timescale 1ns/1ps
`include "port_alt_function_override_regs.svh"

module port_alt_function_override
   import pinmux_pkg::*;
#(
   parameter bit SMALL_PKG = 1'h1
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        tmr3_cmp_a_en_i,
   input  wire logic        tmr3_cmp_a_out_i,
   input  wire logic        tmr3_cmp_b_en_i,
   input  wire logic        tmr3_cmp_b_out_i,
   input  wire logic        tmr3_cmp_c_en_i,
   input  wire logic        tmr3_cmp_c_out_i,
   input  wire logic [3:0]  ext_irq_en_i,
   input  wire logic        serial0_sync_clock_oe_i,
   input  wire logic        serial0_sync_clock_i,
   input  wire logic        serial0_tx_enable_i,
   input  wire logic        serial0_tx_pin_i,
   input  wire logic        serial0_rx_enable_i,
   input  wire logic        pin_change_src8_mask_i,
   input  wire logic        pin_change_group1_en_i,
   input  wire logic        prog_mode_i,
   input  wire logic        prog_data_out_i,
   input  wire logic        test_port_enable_i,
   input  wire logic        tap_shift_instr_state_i,
   input  wire logic        tap_shift_data_state_i,
   input  wire logic        tap_data_out_i,
   input  wire logic        tmr0_cmp_b_en_i,
   input  wire logic        tmr0_cmp_b_out_i,
   input  wire logic        ext_mem_en_i,
   input  wire logic        ext_mem_ale_i,
   input  wire logic        ext_mem_rd_i,
   input  wire logic        ext_mem_wr_i,
   input  wire logic        tmr2_async_i,
   input  wire logic        tmr2_ext_clk_i,
   input  wire logic [7:0]  pe_pin_i,
   input  wire logic [7:0]  pf_pin_i,
   input  wire logic [7:0]  pg_pin_i,
   output pad_t             pe_pad_o,
   output pad_t             pf_pad_o,
   output pad_t             pg_pad_o,
   output logic [3:0]       ext_irq_o,
   output logic             tmr3_capture_in_o,
   output logic             tmr3_ext_clock_in_o,
   output logic             serial0_sync_clock_in_o,
   output logic             serial0_rx_pin_o,
   output logic             pin_change_src8_o,
   output logic             prog_data_in_o,
   output logic             tap_tdi_o,
   output logic             tap_tms_o,
   output logic             tap_tck_o,
   output logic             cmp_neg_in_o,
   output logic             cmp_pos_in_o,
   output logic [7:0]       adc_in_o
);

   // ==========================================================
   // override merge
   function automatic pad_t resolve(input ovr_t o, input logic [7:0] port,
                                    input logic [7:0] dir, input logic pu_off);
      pad_t p;
      logic [7:0] d;
      d     = (o.dir_ovr_en & o.dir_ovr_val) | (~o.dir_ovr_en & dir);
      p.oe  = d;
      p.drv = (o.pinval_ovr_en & o.pinval_ovr_val) | (~o.pinval_ovr_en & port);
      p.pu  = (o.pullup_ovr_en & o.pullup_ovr_val)
            | (~o.pullup_ovr_en & port & ~d & {8{~pu_off}});
      p.ien = (o.inbuf_ovr_en & o.inbuf_ovr_val) | ~o.inbuf_ovr_en;
      return p;
   endfunction

   function automatic logic [31:0] wmerge(input logic [7:0] old, input logic we);
      return {24'h000000, we ? wb_dat_i[7:0] : old};
   endfunction

   state_t st_r;
   state_t st_nxt;
   ovr_t   ovr_e;
   ovr_t   ovr_f;
   ovr_t   ovr_g;
   logic   prog_act;
   logic   tap_shift;
   logic   req;
   logic   wr;

   // ==========================================================
   // port e overrides
   always_comb begin
      prog_act = SMALL_PKG & prog_mode_i;
      ovr_e = '0;
      ovr_e.pinval_ovr_en[5]  = tmr3_cmp_c_en_i;
      ovr_e.pinval_ovr_val[5] = tmr3_cmp_c_out_i;
      ovr_e.pinval_ovr_en[4]  = tmr3_cmp_b_en_i;
      ovr_e.pinval_ovr_val[4] = tmr3_cmp_b_out_i;
      ovr_e.pinval_ovr_en[3]  = tmr3_cmp_a_en_i;
      ovr_e.pinval_ovr_val[3] = tmr3_cmp_a_out_i;
      ovr_e.inbuf_ovr_en[7:4] = ext_irq_en_i;
      ovr_e.inbuf_ovr_val[7:4] = 4'hF;
      ovr_e.dir_ovr_en[2]     = serial0_sync_clock_oe_i;
      ovr_e.dir_ovr_val[2]    = 1'h1;
      ovr_e.pinval_ovr_en[2]  = serial0_sync_clock_oe_i;
      ovr_e.pinval_ovr_val[2] = serial0_sync_clock_i;
      ovr_e.pullup_ovr_en[1]  = serial0_tx_enable_i | prog_act;
      ovr_e.dir_ovr_en[1]     = serial0_tx_enable_i | prog_act;
      ovr_e.dir_ovr_val[1]    = 1'h1;
      ovr_e.pinval_ovr_en[1]  = serial0_tx_enable_i | prog_act;
      ovr_e.pinval_ovr_val[1] = prog_act ? prog_data_out_i : serial0_tx_pin_i;
      ovr_e.pullup_ovr_en[0]  = serial0_rx_enable_i;
      ovr_e.pullup_ovr_val[0] = st_r.e.port[0] & ~st_r.pu_off;
      ovr_e.dir_ovr_en[0]     = serial0_rx_enable_i | prog_act;
      ovr_e.inbuf_ovr_en[0]   = pin_change_src8_mask_i & pin_change_group1_en_i;
      ovr_e.inbuf_ovr_val[0]  = 1'h1;
   end

   // ==========================================================
   // port f and g overrides
   always_comb begin
      tap_shift = tap_shift_instr_state_i | tap_shift_data_state_i;
      ovr_f = '0;
      ovr_f.pullup_ovr_en[7:4]  = {4{test_port_enable_i}};
      ovr_f.pullup_ovr_val[7:4] = 4'hB;
      ovr_f.dir_ovr_en[7:4]     = {4{test_port_enable_i}};
      ovr_f.dir_ovr_val[6]      = tap_shift;
      ovr_f.pinval_ovr_en[6]    = test_port_enable_i;
      ovr_f.pinval_ovr_val[6]   = tap_data_out_i;
      ovr_f.inbuf_ovr_en[7:4]   = {4{test_port_enable_i}};
      ovr_g = '0;
      ovr_g.pinval_ovr_en[5]    = tmr0_cmp_b_en_i;
      ovr_g.pinval_ovr_val[5]   = tmr0_cmp_b_out_i;
      ovr_g.pullup_ovr_en[4]    = tmr2_async_i;
      ovr_g.dir_ovr_en[4]       = tmr2_async_i;
      ovr_g.inbuf_ovr_en[4]     = tmr2_async_i;
      ovr_g.inbuf_ovr_val[4]    = tmr2_ext_clk_i;
      ovr_g.pullup_ovr_en[3]    = tmr2_async_i & tmr2_ext_clk_i;
      ovr_g.dir_ovr_en[3]       = tmr2_async_i & tmr2_ext_clk_i;
      ovr_g.inbuf_ovr_en[3]     = tmr2_async_i & tmr2_ext_clk_i;
      ovr_g.pullup_ovr_en[2:0]  = {3{ext_mem_en_i}};
      ovr_g.dir_ovr_en[2:0]     = {3{ext_mem_en_i}};
      ovr_g.dir_ovr_val[2:0]    = 3'h7;
      ovr_g.pinval_ovr_en[2:0]  = {3{ext_mem_en_i}};
      ovr_g.pinval_ovr_val[2:0] = {ext_mem_ale_i, ext_mem_rd_i, ext_mem_wr_i};
   end

   // ==========================================================
   // next state: sync, pads, wishbone
   always_comb begin
      req = wb_cyc_i & wb_stb_i & ~st_r.ack;
      wr  = req & wb_we_i & wb_sel_i[0];
      st_nxt = st_r;
      st_nxt.e.sync1 = pe_pin_i;
      st_nxt.f.sync1 = pf_pin_i;
      st_nxt.g.sync1 = pg_pin_i;
      st_nxt.e.sync2 = st_r.e.sync1;
      st_nxt.f.sync2 = st_r.f.sync1;
      st_nxt.g.sync2 = st_r.g.sync1;
      st_nxt.e.pad = resolve(ovr_e, st_r.e.port, st_r.e.dir, st_r.pu_off);
      st_nxt.f.pad = resolve(ovr_f, st_r.f.port, st_r.f.dir, st_r.pu_off);
      st_nxt.g.pad = resolve(ovr_g, st_r.g.port, st_r.g.dir, st_r.pu_off);
      st_nxt.e.pin = st_r.e.sync2 & st_nxt.e.pad.ien;
      st_nxt.f.pin = st_r.f.sync2 & st_nxt.f.pad.ien;
      st_nxt.g.pin = st_r.g.sync2 & st_nxt.g.pad.ien;
      st_nxt.ack  = req;
      st_nxt.rdat = 32'h00000000;
      if (req) begin
         case (wb_adr_i[`PAFO_ADR_W-1:0])
            `PAFO_OFS_PORTE: st_nxt.rdat = wmerge(st_r.e.port, wr);
            `PAFO_OFS_DIRE:  st_nxt.rdat = wmerge(st_r.e.dir, wr);
            `PAFO_OFS_PINE:  st_nxt.rdat = {24'h000000, st_r.e.pin};
            `PAFO_OFS_PORTF: st_nxt.rdat = wmerge(st_r.f.port, wr);
            `PAFO_OFS_DIRF:  st_nxt.rdat = wmerge(st_r.f.dir, wr);
            `PAFO_OFS_PINF:  st_nxt.rdat = {24'h000000, st_r.f.pin};
            `PAFO_OFS_PORTG: st_nxt.rdat = wmerge(st_r.g.port, wr);
            `PAFO_OFS_DIRG:  st_nxt.rdat = wmerge(st_r.g.dir, wr);
            `PAFO_OFS_PING:  st_nxt.rdat = {24'h000000, st_r.g.pin};
            `PAFO_OFS_CTRL:  st_nxt.rdat = {31'h00000000,
                                            wr ? wb_dat_i[`PAFO_CTRL_PU_OFF_BIT] : st_r.pu_off};
            default:         st_nxt.rdat = 32'h00000000;
         endcase
         if (wr) begin
            case (wb_adr_i[`PAFO_ADR_W-1:0])
               `PAFO_OFS_PORTE: st_nxt.e.port = wb_dat_i[7:0];
               `PAFO_OFS_DIRE:  st_nxt.e.dir  = wb_dat_i[7:0];
               `PAFO_OFS_PORTF: st_nxt.f.port = wb_dat_i[7:0];
               `PAFO_OFS_DIRF:  st_nxt.f.dir  = wb_dat_i[7:0];
               `PAFO_OFS_PORTG: st_nxt.g.port = wb_dat_i[7:0];
               `PAFO_OFS_DIRG:  st_nxt.g.dir  = wb_dat_i[7:0];
               `PAFO_OFS_CTRL:  st_nxt.pu_off = wb_dat_i[`PAFO_CTRL_PU_OFF_BIT];
               default:         st_nxt.pu_off = st_r.pu_off;
            endcase
         end
      end
      if (rst_i) begin
         st_nxt = '0;
         st_nxt.e.port = `PAFO_RST_PORT;
         st_nxt.e.dir  = `PAFO_RST_DIR;
         st_nxt.pu_off = `PAFO_RST_CTRL;
         // test pins keep their pull-ups through reset
         st_nxt.f.pad.pu = {test_port_enable_i, 1'h0, {2{test_port_enable_i}}, 4'h0};
      end
   end

   always_ff @(posedge clk_i) begin
      st_r <= st_nxt;
   end

   // ==========================================================
   // outputs
   assign wb_dat_o                = st_r.rdat;
   assign wb_ack_o                = st_r.ack;
   assign pe_pad_o                = st_r.e.pad;
   assign pf_pad_o                = st_r.f.pad;
   assign pg_pad_o                = st_r.g.pad;
   assign ext_irq_o               = st_r.e.pin[7:4];
   assign tmr3_capture_in_o       = st_r.e.pin[7];
   assign tmr3_ext_clock_in_o     = st_r.e.pin[6];
   assign serial0_sync_clock_in_o = st_r.e.pin[2];
   assign serial0_rx_pin_o        = st_r.e.pin[0];
   assign pin_change_src8_o       = st_r.e.pin[0];
   assign prog_data_in_o          = st_r.e.pin[0];
   assign tap_tdi_o               = st_r.f.sync2[7];
   assign tap_tms_o               = st_r.f.sync2[5];
   assign tap_tck_o               = st_r.f.sync2[4];
   assign cmp_neg_in_o            = st_r.e.sync2[3];
   assign cmp_pos_in_o            = st_r.e.sync2[2];
   assign adc_in_o                = st_r.f.sync2;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_cmp_c;
      tmr3_cmp_c_en_i |=> pe_pad_o.drv[5] == $past(tmr3_cmp_c_out_i)
                          && pe_pad_o.oe[5] == $past(st_r.e.dir[5]);
   endproperty
   a_cmp_c: assert property (p_cmp_c) else $error("pe5 compare c wrong");
   property p_cmp_b;
      tmr3_cmp_b_en_i |=> pe_pad_o.drv[4] == $past(tmr3_cmp_b_out_i)
                          && pe_pad_o.oe[4] == $past(st_r.e.dir[4]);
   endproperty
   a_cmp_b: assert property (p_cmp_b) else $error("pe4 compare b wrong");
   property p_cmp_a;
      tmr3_cmp_a_en_i |=> pe_pad_o.drv[3] == $past(tmr3_cmp_a_out_i);
   endproperty
   a_cmp_a: assert property (p_cmp_a) else $error("pe3 compare a wrong");
   property p_irq_buf;
      ext_irq_en_i[3] |=> pe_pad_o.ien[7];
   endproperty
   a_irq_buf: assert property (p_irq_buf) else $error("pe7 buffer off");
   property p_xck;
      serial0_sync_clock_oe_i |=> pe_pad_o.oe[2] && pe_pad_o.drv[2] == $past(serial0_sync_clock_i);
   endproperty
   a_xck: assert property (p_xck) else $error("pe2 clock not driven");
   sequence s_rx_held;
      (serial0_rx_enable_i && pe_pin_i[0]) [*4];
   endsequence
   property p_rx_path;
      s_rx_held |-> serial0_rx_pin_o;
   endproperty
   a_rx_path: assert property (p_rx_path) else $error("rx data lost");
   property p_rx_pull;
      serial0_rx_enable_i |=> !pe_pad_o.oe[0]
                              && pe_pad_o.pu[0] == $past(st_r.e.port[0] & ~st_r.pu_off);
   endproperty
   a_rx_pull: assert property (p_rx_pull) else $error("pe0 input or pull-up wrong");
   property p_tx;
      serial0_tx_enable_i && !prog_act |=> pe_pad_o.oe[1] && !pe_pad_o.pu[1]
                                           && pe_pad_o.drv[1] == $past(serial0_tx_pin_i);
   endproperty
   a_tx: assert property (p_tx) else $error("pe1 transmit wrong");
   property p_pcint;
      pin_change_src8_mask_i && pin_change_group1_en_i |=> pe_pad_o.ien[0];
   endproperty
   a_pcint: assert property (p_pcint) else $error("pe0 buffer off");
   property p_tap_pins;
      test_port_enable_i |=> pf_pad_o.pu[7] && pf_pad_o.pu[5] && pf_pad_o.pu[4]
                             && !pf_pad_o.oe[7] && !pf_pad_o.oe[5] && !pf_pad_o.oe[4];
   endproperty
   a_tap_pins: assert property (p_tap_pins) else $error("tap pins not taken");
   property p_tdo;
      test_port_enable_i |=> pf_pad_o.oe[6] == $past(tap_shift);
   endproperty
   a_tdo: assert property (p_tdo) else $error("tdo drive wrong");
   property p_adc;
      1'h1 |=> pf_pad_o.oe[3:0] == $past(st_r.f.dir[3:0]);
   endproperty
   a_adc: assert property (p_adc) else $error("pf3..0 overridden");
   property p_mem;
      ext_mem_en_i |=> pg_pad_o.oe[2:0] == 3'h7;
   endproperty
   a_mem: assert property (p_mem) else $error("pg strobes not driven");

endmodule

// ### port_alt_function_override_regs.svh
/*
 * register offsets, field positions and reset values of the pin override block
 * assumes a 32-bit classic wishbone slave with word-aligned byte addresses
 */
`ifndef PORT_ALT_FUNCTION_OVERRIDE_REGS_SVH
`define PORT_ALT_FUNCTION_OVERRIDE_REGS_SVH

`define PAFO_ADR_W        6
`define PAFO_OFS_PORTE    6'h00
`define PAFO_OFS_DIRE     6'h04
`define PAFO_OFS_PINE     6'h08
`define PAFO_OFS_PORTF    6'h0C
`define PAFO_OFS_DIRF     6'h10
`define PAFO_OFS_PINF     6'h14
`define PAFO_OFS_PORTG    6'h18
`define PAFO_OFS_DIRG     6'h1C
`define PAFO_OFS_PING     6'h20
`define PAFO_OFS_CTRL     6'h24
`define PAFO_CTRL_PU_OFF_BIT 0
`define PAFO_RST_PORT     8'h00
`define PAFO_RST_DIR      8'h00
`define PAFO_RST_CTRL     1'h0

`endif

// ### pinmux_pkg.sv
/*
 * types shared by the pin override block
 * assumes eight pins per port
 */
package pinmux_pkg;

   // one override set, one bit per pin
   typedef struct packed {
      logic [7:0] pullup_ovr_en;
      logic [7:0] pullup_ovr_val;
      logic [7:0] dir_ovr_en;
      logic [7:0] dir_ovr_val;
      logic [7:0] pinval_ovr_en;
      logic [7:0] pinval_ovr_val;
      logic [7:0] inbuf_ovr_en;
      logic [7:0] inbuf_ovr_val;
   } ovr_t;

   // resolved pad controls of one port
   typedef struct packed {
      logic [7:0] drv;
      logic [7:0] oe;
      logic [7:0] pu;
      logic [7:0] ien;
   } pad_t;

   typedef struct packed {
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [7:0] pin;
      logic [7:0] port;
      logic [7:0] dir;
      pad_t       pad;
   } port_state_t;

   typedef struct packed {
      port_state_t e;
      port_state_t f;
      port_state_t g;
      logic        pu_off;
      logic        ack;
      logic [31:0] rdat;
   } state_t;

endpackage

// ### pad_far_side.sv
/* far-side pad model: resolves each pin from the pad controls of the block
   assumes pad_t from pinmux_pkg; ext_i is what the board drives on a pin */
`timescale 1ns/1ps

module pad_far_side
   import pinmux_pkg::*;
(
   input  wire pad_t       pad_i,
   input  wire logic [7:0] ext_i,
   output logic      [7:0] pin_o
);
   // =====================================================
   // driven pins win, pulled pins read high, others follow the board
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_o[i] = pad_i.oe[i] ? pad_i.drv[i] : (pad_i.pu[i] ? 1'h1 : ext_i[i]);
      end
   end
endmodule

// ### testbench.sv
/* self-checking bench of the pin override block, one pad model per port
   assumes pinmux_pkg, the register offset header and pad_far_side */
`timescale 1ns/1ps
`include "port_alt_function_override_regs.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin num_errors++; \
   $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module testbench
   import pinmux_pkg::*;
;
   logic        clk_i = '0, rst_i = '1, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, wb_ack_o;
   logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, q;
   logic [3:0]  wb_sel_i = '0, ext_irq_en_i = '0, ext_irq_o;
   logic        tmr3_cmp_a_en_i = '0, tmr3_cmp_a_out_i = '0, tmr3_cmp_b_en_i = '0,
                tmr3_cmp_b_out_i = '0, tmr3_cmp_c_en_i = '0, tmr3_cmp_c_out_i = '0,
                serial0_sync_clock_oe_i = '0, serial0_sync_clock_i = '0,
                serial0_tx_enable_i = '0, serial0_tx_pin_i = '0, serial0_rx_enable_i = '0,
                pin_change_src8_mask_i = '0, pin_change_group1_en_i = '0, prog_mode_i = '0,
                prog_data_out_i = '0, test_port_enable_i = '0, tap_shift_instr_state_i = '0,
                tap_shift_data_state_i = '0, tap_data_out_i = '0, tmr0_cmp_b_en_i = '0,
                tmr0_cmp_b_out_i = '0, ext_mem_en_i = '0, ext_mem_ale_i = '0,
                ext_mem_rd_i = '0, ext_mem_wr_i = '0, tmr2_async_i = '0, tmr2_ext_clk_i = '0;
   logic        tmr3_capture_in_o, tmr3_ext_clock_in_o, serial0_sync_clock_in_o,
                serial0_rx_pin_o, pin_change_src8_o, prog_data_in_o, tap_tdi_o, tap_tms_o,
                tap_tck_o, cmp_neg_in_o, cmp_pos_in_o;
   logic [7:0]  pe_pin_i, pf_pin_i, pg_pin_i, adc_in_o, e_ext = '0, f_ext = '0, g_ext = '0;
   pad_t        pe_pad_o, pf_pad_o, pg_pad_o;
   int          num_errors = 0, n_checks = 0;

   port_alt_function_override #(.SMALL_PKG(1'h1)) dut_u (.clk_i, .rst_i, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .tmr3_cmp_a_en_i, .tmr3_cmp_a_out_i, .tmr3_cmp_b_en_i, .tmr3_cmp_b_out_i,
      .tmr3_cmp_c_en_i, .tmr3_cmp_c_out_i, .ext_irq_en_i, .serial0_sync_clock_oe_i,
      .serial0_sync_clock_i, .serial0_tx_enable_i, .serial0_tx_pin_i, .serial0_rx_enable_i,
      .pin_change_src8_mask_i, .pin_change_group1_en_i, .prog_mode_i, .prog_data_out_i,
      .test_port_enable_i, .tap_shift_instr_state_i, .tap_shift_data_state_i,
      .tap_data_out_i, .tmr0_cmp_b_en_i, .tmr0_cmp_b_out_i, .ext_mem_en_i, .ext_mem_ale_i,
      .ext_mem_rd_i, .ext_mem_wr_i, .tmr2_async_i, .tmr2_ext_clk_i, .pe_pin_i, .pf_pin_i,
      .pg_pin_i, .pe_pad_o, .pf_pad_o, .pg_pad_o, .ext_irq_o, .tmr3_capture_in_o,
      .tmr3_ext_clock_in_o, .serial0_sync_clock_in_o, .serial0_rx_pin_o, .pin_change_src8_o,
      .prog_data_in_o, .tap_tdi_o, .tap_tms_o, .tap_tck_o, .cmp_neg_in_o, .cmp_pos_in_o,
      .adc_in_o);
   pad_far_side e_u (.pad_i(pe_pad_o), .ext_i(e_ext), .pin_o(pe_pin_i));
   pad_far_side f_u (.pad_i(pf_pad_o), .ext_i(f_ext), .pin_o(pf_pin_i));
   pad_far_side g_u (.pad_i(pg_pad_o), .ext_i(g_ext), .pin_o(pg_pin_i));

   initial forever #12.5 clk_i = ~clk_i;

   // =====================================================
   // shared tasks
   task automatic close_out;
      if (num_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic wb(input logic we, input logic [5:0] a, input logic [7:0] d,
                     output logic [31:0] r);
      int t;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, we, 4'h1};
      wb_adr_i <= {26'h0, a};
      wb_dat_i <= {24'h0, d};
      t = 0;
      do begin
         @(posedge clk_i);
         t++;
      end while (wb_ack_o !== 1'h1 && t < 20);
      r = wb_dat_o;
      if (t >= 20) num_errors++;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
   endtask

   // =====================================================
   // scenarios
   task automatic t_regs;
      wb('0, `PAFO_OFS_DIRE, 8'h00, q);
      `CHK("dire reset", 32'h0, q);
      wb('1, `PAFO_OFS_DIRE, 8'h38, q);
      wb('0, `PAFO_OFS_DIRE, 8'h00, q);
      `CHK("dire", 32'h38, q);
      wb('0, 6'h3C, 8'h00, q);
      `CHK("unmapped", 32'h0, q);
      tick(2);
      `CHK("pe oe", 8'h38, pe_pad_o.oe);
   endtask

   task automatic t_cmp;
      @(posedge clk_i);
      {tmr3_cmp_c_en_i, tmr3_cmp_b_en_i, tmr3_cmp_a_en_i} <= 3'h7;
      {tmr3_cmp_c_out_i, tmr3_cmp_b_out_i, tmr3_cmp_a_out_i} <= 3'h5;
      tick(4);
      `CHK("cmp drv", 3'h5, pe_pad_o.drv[5:3]);
      `CHK("cmp oe", 3'h7, pe_pad_o.oe[5:3]);
      `CHK("cmp neg", 1'h1, cmp_neg_in_o);
      wb('1, `PAFO_OFS_DIRE, 8'h00, q);
      tick(2);
      `CHK("cmp oe off", 3'h0, pe_pad_o.oe[5:3]);
      `CHK("cmp drv kept", 3'h5, pe_pad_o.drv[5:3]);
      @(posedge clk_i);
      {tmr3_cmp_c_en_i, tmr3_cmp_b_en_i, tmr3_cmp_a_en_i} <= 3'h0;
      tick(2);
      `CHK("port drv", 3'h0, pe_pad_o.drv[5:3]);
   endtask

   task automatic t_tx;
      wb('1, `PAFO_OFS_DIRE, 8'h01, q);
      wb('1, `PAFO_OFS_PORTE, 8'h02, q);
      @(posedge clk_i);
      serial0_tx_enable_i <= '1;
      tick(2);
      `CHK("tx oe", 1'h1, pe_pad_o.oe[1]);
      `CHK("tx pu", 1'h0, pe_pad_o.pu[1]);
      `CHK("tx drv", 1'h0, pe_pad_o.drv[1]);
      @(posedge clk_i);
      {prog_mode_i, prog_data_out_i} <= 2'h3;
      e_ext <= 8'h01;
      tick(4);
      `CHK("prog drv", 1'h1, pe_pad_o.drv[1]);
      `CHK("prog oe", 1'h0, pe_pad_o.oe[0]);
      `CHK("prog in", 1'h1, prog_data_in_o);
      @(posedge clk_i);
      {prog_mode_i, serial0_tx_enable_i} <= 2'h0;
      e_ext <= 8'h00;
   endtask

   task automatic t_rx;
      wb('1, `PAFO_OFS_DIRE, 8'h01, q);
      wb('1, `PAFO_OFS_PORTE, 8'h01, q);
      @(posedge clk_i);
      serial0_rx_enable_i <= '1;
      {pin_change_src8_mask_i, pin_change_group1_en_i} <= 2'h3;
      tick(2);
      `CHK("rx oe", 1'h0, pe_pad_o.oe[0]);
      `CHK("rx pu", 1'h1, pe_pad_o.pu[0]);
      `CHK("pc ien", 1'h1, pe_pad_o.ien[0]);
      wb('1, `PAFO_OFS_CTRL, 8'h01, q);
      tick(4);
      `CHK("rx pu off", 1'h0, pe_pad_o.pu[0]);
      `CHK("rx low", 1'h0, serial0_rx_pin_o);
      @(posedge clk_i);
      e_ext <= 8'h01;
      tick(4);
      `CHK("rx high", 1'h1, serial0_rx_pin_o);
      `CHK("pc src", 1'h1, pin_change_src8_o);
      @(posedge clk_i);
      serial0_rx_enable_i <= '0;
   endtask

   task automatic t_sclk_irq;
      @(posedge clk_i);
      {serial0_sync_clock_oe_i, serial0_sync_clock_i} <= 2'h3;
      tick(4);
      `CHK("sclk oe", 1'h1, pe_pad_o.oe[2]);
      `CHK("sclk drv", 1'h1, pe_pad_o.drv[2]);
      `CHK("cmp pos", 1'h1, cmp_pos_in_o);
      @(posedge clk_i);
      serial0_sync_clock_oe_i <= '0;
      ext_irq_en_i <= 4'hF;
      e_ext <= 8'hA4;
      tick(4);
      `CHK("sclk in oe", 1'h0, pe_pad_o.oe[2]);
      `CHK("sclk in", 1'h1, serial0_sync_clock_in_o);
      `CHK("irq ien", 4'hF, pe_pad_o.ien[7:4]);
      `CHK("irq", 4'hA, ext_irq_o);
      `CHK("capture", 1'h1, tmr3_capture_in_o);
      `CHK("tmr3 clock", 1'h0, tmr3_ext_clock_in_o);
   endtask

   task automatic t_tap;
      wb('1, `PAFO_OFS_DIRF, 8'hFF, q);
      @(posedge clk_i);
      {test_port_enable_i, tap_data_out_i} <= 2'h3;
      f_ext <= 8'h5A;
      tick(2);
      `CHK("tap pu", 4'hB, pf_pad_o.pu[7:4]);
      `CHK("tap oe", 4'h0, pf_pad_o.oe[7:4]);
      `CHK("tap ien", 4'h0, pf_pad_o.ien[7:4]);
      `CHK("adc oe", 4'hF, pf_pad_o.oe[3:0]);
      `CHK("adc ien", 4'hF, pf_pad_o.ien[3:0]);
      @(posedge clk_i);
      tap_shift_data_state_i <= '1;
      tick(2);
      `CHK("tdo dr", 2'h3, {pf_pad_o.oe[6], pf_pad_o.drv[6]});
      @(posedge clk_i);
      {tap_shift_data_state_i, tap_shift_instr_state_i} <= 2'h1;
      tick(2);
      `CHK("tdo ir", 1'h1, pf_pad_o.oe[6]);
      @(posedge clk_i);
      tap_shift_instr_state_i <= '0;
      rst_i <= '1;
      tick(2);
      `CHK("pu in reset", 4'hB, pf_pad_o.pu[7:4]);
      @(posedge clk_i);
      rst_i <= '0;
      tick(4);
      `CHK("adc", 8'hFA, adc_in_o);
      `CHK("tap in", 3'h7, {tap_tdi_o, tap_tms_o, tap_tck_o});
      @(posedge clk_i);
      test_port_enable_i <= '0;
   endtask

   task automatic t_pg;
      wb('1, `PAFO_OFS_PORTG, 8'h18, q);
      @(posedge clk_i);
      {ext_mem_en_i, ext_mem_ale_i, ext_mem_rd_i, ext_mem_wr_i} <= 4'hD;
      {tmr0_cmp_b_en_i, tmr0_cmp_b_out_i} <= 2'h3;
      tmr2_async_i <= '1;
      tick(2);
      `CHK("mem oe", 3'h7, pg_pad_o.oe[2:0]);
      `CHK("mem drv", 3'h5, pg_pad_o.drv[2:0]);
      `CHK("t0 drv", 1'h1, pg_pad_o.drv[5]);
      `CHK("osc pu", 2'h1, pg_pad_o.pu[4:3]);
      `CHK("osc ien", 2'h1, pg_pad_o.ien[4:3]);
      @(posedge clk_i);
      tmr2_ext_clk_i <= '1;
      tick(2);
      `CHK("xtal pu", 2'h0, pg_pad_o.pu[4:3]);
      `CHK("xtal ien", 2'h2, pg_pad_o.ien[4:3]);
   endtask

   // =====================================================
   // main sequence and watchdog
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= '0;
      t_regs();
      t_cmp();
      t_tx();
      t_rx();
      t_sclk_irq();
      t_tap();
      t_pg();
      close_out();
   end

   initial begin
      #50000;
      num_errors++;
      close_out();
   end
endmodule
